// ### scl_strap_latch.sv
// Strap configuration latch with AXI4-Lite register access
//
// How it works
// - strap pins float while reset held
// - sample strap levels at reset release
// - drive strap pins once reset released
// - software reset also recaptures straps
// - weak pull gives default when unstrapped
// - flow control strap, 1 enables
// - link-up strap 0 gives fast link-up
// - normal link-up negotiation pair decode
// - fast link-up: full duplex, master select
// - fast link-up: low strap picks speed
// - management interface select, 1x SPI
// - start strap 0 holds forwarding off until software sets the CTRL start bit
// - port mode pair decode, RGMII default
// - sub-mode picks PHY/clock or MAC/normal
// - port speed strap, 0 gigabit
// - in-band management strap, 1 enables
// - LED pins active low after reset
`timescale 1ns/1ps
module scl_strap_latch
   import scl_pkg::*;
#(
   parameter int SOFT_HIZ_CYC = SCL_SOFT_HIZ_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] pad_i,
   output scl_pad_s pad_o,
   input wire logic [6:0] led_on,
   input wire logic [8:0] func_out,
   output scl_dec_s cfg_o,
   output logic cfg_valid,
   output logic switch_fwd_en
);

   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] SOFT_LOAD = CNT_W'(SOFT_HIZ_CYC);

   typedef struct packed {
      scl_state_e st;
      logic [CNT_W-1:0] cnt;
      logic [15:0] raw;
      scl_dec_s dec;
      logic cfg_valid;
      logic fwd;
      logic start_bit;
      scl_pad_s pad;
      logic aw_have;
      logic [11:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } scl_regs_s;

   scl_regs_s r_q;
   scl_regs_s r_d;
   logic [15:0] sync_q;
   logic soft_rst;
   logic wr_ctrl;
   logic [11:0] wa;
   logic [11:0] ra;

   ////////////////////////////////////////////////////////////////////////
   // Pad input synchroniser
   scl_sync #(
      .W(SCL_NPIN)
   ) u_sync (
      .clk(clk),
      .d(pad_i),
      .q(sync_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Strap decode
   function automatic scl_port_s port_decode(input logic hi, input logic lo,
                                             input logic sub,
                                             input logic spd);
      scl_port_s p;
      p.mode = scl_pmode_e'({hi, lo});
      if (p.mode == SCL_PM_RSVD) begin
         p.mode = SCL_PM_RGMII;
      end
      p.mii_mac_rmii_norm = sub;
      p.rmii_ref_out = (p.mode == SCL_PM_RMII) && !sub;
      p.mii_phy = (p.mode == SCL_PM_MII) && !sub;
      p.speed_10_100 = spd;
      return p;
   endfunction

   function automatic scl_dec_s decode(input logic [15:0] s);
      scl_dec_s c;
      logic [1:0] neg;
      neg = {s[SCL_P_NEG_HI], s[SCL_P_NEG_LO]};
      c = '0;
      c.flow_ctrl_en = s[SCL_P_FLOW];
      c.fast_linkup = !s[SCL_P_LINKUP];
      if (c.fast_linkup) begin
         c.autoneg_en = 1'b0;
         c.auto_mdix_en = 1'b0;
         c.full_duplex = 1'b1;
         c.gig_master = s[SCL_P_NEG_HI];
         c.phy_speed_100 = s[SCL_P_NEG_LO];
      end else begin
         c.auto_mdix_en = 1'b1;
         case (neg)
            2'h1: c.autoneg_en = 1'b0;
            2'h2: c.nand_tree = 1'b1;
            default: c.autoneg_en = 1'b1;
         endcase
      end
      if (s[SCL_P_MGMT_HI]) begin
         c.mgmt = SCL_MGMT_SPI;
      end else if (s[SCL_P_MGMT_LO]) begin
         c.mgmt = SCL_MGMT_I2C;
      end else begin
         c.mgmt = SCL_MGMT_MDIO;
      end
      c.switch_start = s[SCL_P_START];
      c.inband_mgmt_en = s[SCL_P_INBAND];
      c.port_a = port_decode(s[SCL_P_A_MODE_HI], s[SCL_P_A_MODE_LO],
                             s[SCL_P_A_SUB], s[SCL_P_A_SPEED]);
      c.port_b = port_decode(s[SCL_P_B_MODE_HI], s[SCL_P_B_MODE_LO],
                             s[SCL_P_B_SUB], s[SCL_P_B_SPEED]);
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      r_d = r_q;
      soft_rst = 1'b0;
      wr_ctrl = 1'b0;
      wa = {r_q.awaddr[11:2], 2'h0};
      ra = {s_axi_araddr[11:2], 2'h0};

      // Write channel
      if (r_q.bvalid && s_axi_bready) begin
         r_d.bvalid = 1'b0;
      end
      if (r_q.awready && s_axi_awvalid) begin
         r_d.aw_have = 1'b1;
         r_d.awaddr = s_axi_awaddr;
      end
      if (r_q.wready && s_axi_wvalid) begin
         r_d.w_have = 1'b1;
         r_d.wdata = s_axi_wdata;
         r_d.wstrb = s_axi_wstrb;
      end
      if (r_q.aw_have && r_q.w_have && !r_q.bvalid) begin
         r_d.aw_have = 1'b0;
         r_d.w_have = 1'b0;
         r_d.bvalid = 1'b1;
         r_d.bresp = SCL_RESP_OKAY;
         case (wa)
            SCL_OFF_CTRL: begin
               wr_ctrl = r_q.wstrb[0];
               soft_rst = r_q.wstrb[0] && r_q.wdata[SCL_CTRL_SOFT_RST_BIT];
            end
            SCL_OFF_CFG, SCL_OFF_DEC: begin
               r_d.bresp = SCL_RESP_OKAY;
            end
            default: begin
               r_d.bresp = SCL_RESP_SLVERR;
            end
         endcase
      end
      r_d.awready = !r_d.aw_have;
      r_d.wready = !r_d.w_have;

      // Read channel
      if (r_q.rvalid && s_axi_rready) begin
         r_d.rvalid = 1'b0;
      end
      if (r_q.arready && s_axi_arvalid) begin
         r_d.rvalid = 1'b1;
         r_d.rresp = SCL_RESP_OKAY;
         case (ra)
            SCL_OFF_CFG: begin
               r_d.rdata = 32'h0;
               r_d.rdata[15:0] = r_q.raw;
               r_d.rdata[SCL_CFG_VALID_BIT] = r_q.cfg_valid;
            end
            SCL_OFF_DEC: begin
               r_d.rdata = 32'h0;
               r_d.rdata[23:0] = r_q.dec;
               r_d.rdata[SCL_DEC_FWD_BIT] = r_q.fwd;
            end
            SCL_OFF_CTRL: begin
               r_d.rdata = 32'h0;
               r_d.rdata[SCL_CTRL_START_BIT] = r_q.start_bit;
            end
            default: begin
               r_d.rdata = 32'h0;
               r_d.rresp = SCL_RESP_SLVERR;
            end
         endcase
      end
      r_d.arready = !r_d.rvalid;

      // Strap sequencer
      case (r_q.st)
         SCL_ST_HIZ: begin
            if (r_q.cnt == '0) begin
               r_d.raw = sync_q;
               r_d.st = SCL_ST_RUN;
            end else begin
               r_d.cnt = r_q.cnt - CNT_W'(1);
            end
         end
         SCL_ST_RUN: begin
            r_d.raw = r_q.raw;
         end
         default: begin
            r_d.st = SCL_ST_HIZ;
         end
      endcase
      if (soft_rst) begin
         r_d.st = SCL_ST_HIZ;
         r_d.cnt = SOFT_LOAD;
         r_d.start_bit = 1'b0;
      end
      // A start write in the same beat as a soft reset wins
      if (wr_ctrl) begin
         r_d.start_bit = r_q.wdata[SCL_CTRL_START_BIT];
      end

      r_d.cfg_valid = (r_d.st == SCL_ST_RUN);
      r_d.dec = decode(r_d.raw);
      r_d.fwd = r_d.cfg_valid &&
                (r_d.dec.switch_start || r_d.start_bit);

      // Pads float until straps are taken, then drive
      r_d.pad.oe = r_d.cfg_valid ? 16'hFFFF : 16'h0000;
      r_d.pad.out = {func_out, ~led_on};
      r_d.pad.pull = SCL_PULL_DEFAULT;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r_q <= '0;
         r_q.st <= SCL_ST_HIZ;
         r_q.raw <= SCL_PULL_DEFAULT;
         r_q.pad.pull <= SCL_PULL_DEFAULT;
         r_q.awready <= 1'b1;
         r_q.wready <= 1'b1;
         r_q.arready <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready = r_q.awready;
   assign s_axi_wready = r_q.wready;
   assign s_axi_bresp = r_q.bresp;
   assign s_axi_bvalid = r_q.bvalid;
   assign s_axi_arready = r_q.arready;
   assign s_axi_rdata = r_q.rdata;
   assign s_axi_rresp = r_q.rresp;
   assign s_axi_rvalid = r_q.rvalid;
   assign pad_o = r_q.pad;
   assign cfg_o = r_q.dec;
   assign cfg_valid = r_q.cfg_valid;
   assign switch_fwd_en = r_q.fwd;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   localparam int SOFT_SPAN = 300;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_release;
      $rose(rst_b);
   endsequence

   sequence s_soft_req;
      soft_rst;
   endsequence

   a_release_hiz_pads: assert property (
      s_release |-> r_q.pad.oe == '0)
      else $error("pads driven at reset release");
   a_soft_hiz_pads: assert property (
      s_soft_req |=> (r_q.pad.oe == '0)[*3])
      else $error("pads driven during soft reset");
   a_release_capture: assert property (
      s_release |=> r_q.raw == $past(sync_q))
      else $error("straps not taken at reset release");
   a_release_drive: assert property (
      s_release |=> r_q.pad.oe == '1 && r_q.cfg_valid)
      else $error("pads not driven after release");
   a_soft_recapture: assert property (
      s_soft_req |-> ##[2:SOFT_SPAN] (r_q.cfg_valid &&
                                     r_q.raw == $past(sync_q)))
      else $error("soft reset did not recapture straps");
   a_flow_ctrl_map: assert property (
      r_q.cfg_valid |-> r_q.dec.flow_ctrl_en == r_q.raw[SCL_P_FLOW])
      else $error("flow control strap mismatch");
   a_fast_linkup_map: assert property (
      r_q.cfg_valid && !r_q.raw[SCL_P_LINKUP] |-> !r_q.dec.autoneg_en &&
      r_q.dec.full_duplex && !r_q.dec.nand_tree)
      else $error("fast link-up decode wrong");
   a_nand_tree_map: assert property (
      r_q.cfg_valid && r_q.raw[SCL_P_LINKUP] && r_q.raw[SCL_P_NEG_HI] &&
      !r_q.raw[SCL_P_NEG_LO] |-> r_q.dec.nand_tree && !r_q.dec.autoneg_en)
      else $error("nand tree decode wrong");
   a_mgmt_spi_map: assert property (
      r_q.cfg_valid && r_q.raw[SCL_P_MGMT_HI] |->
      r_q.dec.mgmt == SCL_MGMT_SPI)
      else $error("management select decode wrong");
   a_switch_hold: assert property (
      r_q.cfg_valid && !r_q.raw[SCL_P_START] && !r_q.start_bit |->
      !r_q.fwd)
      else $error("forwarding without start");
   a_port_mode_legal: assert property (
      r_q.cfg_valid |-> r_q.dec.port_a.mode != SCL_PM_RSVD &&
      r_q.dec.port_b.mode != SCL_PM_RSVD)
      else $error("reserved port mode reached output");
   a_led_drive_low: assert property (
      r_q.cfg_valid && $past(r_q.cfg_valid) |->
      r_q.pad.out[6:0] == ~$past(led_on))
      else $error("LED pin polarity wrong");
   a_strap_stable: assert property (
      r_q.cfg_valid && $past(r_q.cfg_valid) |-> $stable(r_q.raw))
      else $error("latched straps changed");

endmodule // scl_strap_latch

// ### scl_pkg.sv
// Shared constants, types and layouts of the strap configuration latch
package scl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Strap pin positions on the pad bus
   localparam int SCL_NPIN = 16;
   localparam int SCL_NLED = 7;
   localparam int SCL_NFUNC = 9;
   localparam int SCL_P_FLOW = 0;
   localparam int SCL_P_LINKUP = 1;
   localparam int SCL_P_NEG_HI = 2;
   localparam int SCL_P_NEG_LO = 3;
   localparam int SCL_P_MGMT_HI = 4;
   localparam int SCL_P_MGMT_LO = 5;
   localparam int SCL_P_START = 6;
   localparam int SCL_P_A_MODE_HI = 7;
   localparam int SCL_P_A_MODE_LO = 8;
   localparam int SCL_P_A_SUB = 9;
   localparam int SCL_P_A_SPEED = 10;
   localparam int SCL_P_B_MODE_HI = 11;
   localparam int SCL_P_B_MODE_LO = 12;
   localparam int SCL_P_B_SUB = 13;
   localparam int SCL_P_B_SPEED = 14;
   localparam int SCL_P_INBAND = 15;

   // Weak pull per pin: LED pins pull up, receive data pins pull down
   localparam logic [15:0] SCL_PULL_DEFAULT = 16'h007F;

   ////////////////////////////////////////////////////////////////////////
   // Register map and fields
   localparam int SCL_ADDR_W = 12;
   localparam logic [11:0] SCL_OFF_CFG = 12'h000;
   localparam logic [11:0] SCL_OFF_DEC = 12'h004;
   localparam logic [11:0] SCL_OFF_CTRL = 12'h008;
   localparam int SCL_CFG_VALID_BIT = 16;
   localparam int SCL_DEC_FWD_BIT = 24;
   localparam int SCL_CTRL_START_BIT = 0;
   localparam int SCL_CTRL_SOFT_RST_BIT = 1;
   localparam logic [1:0] SCL_RESP_OKAY = 2'h0;
   localparam logic [1:0] SCL_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int SCL_CLK_NS = 5;
   localparam int SCL_SOFT_HIZ_NS = 100;
   localparam int SCL_SOFT_HIZ_CYC =
      (SCL_SOFT_HIZ_NS + SCL_CLK_NS - 1) / SCL_CLK_NS;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      SCL_ST_HIZ = 2'h1,
      SCL_ST_RUN = 2'h2
   } scl_state_e;

   typedef enum logic [1:0] {
      SCL_MGMT_MDIO = 2'h0,
      SCL_MGMT_I2C = 2'h1,
      SCL_MGMT_SPI = 2'h2
   } scl_mgmt_e;

   typedef enum logic [1:0] {
      SCL_PM_RGMII = 2'h0,
      SCL_PM_RMII = 2'h1,
      SCL_PM_RSVD = 2'h2,
      SCL_PM_MII = 2'h3
   } scl_pmode_e;

   typedef struct packed {
      scl_pmode_e mode;
      logic mii_mac_rmii_norm;
      logic speed_10_100;
      logic rmii_ref_out;
      logic mii_phy;
   } scl_port_s;

   typedef struct packed {
      logic flow_ctrl_en;
      logic fast_linkup;
      logic autoneg_en;
      logic auto_mdix_en;
      logic nand_tree;
      logic full_duplex;
      logic gig_master;
      logic phy_speed_100;
      scl_mgmt_e mgmt;
      logic switch_start;
      logic inband_mgmt_en;
      scl_port_s port_a;
      scl_port_s port_b;
   } scl_dec_s;

   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
      logic [15:0] pull;
   } scl_pad_s;

endpackage

// ### scl_sync.sv
// Two-stage synchroniser for pad inputs
`timescale 1ns/1ps
module scl_sync #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } scl_sync_s;

   scl_sync_s r_q;
   scl_sync_s r_d;

   // No reset: pins must be tracked while system reset is held
   always_comb begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk) begin
      r_q <= r_d;
   end

   assign q = r_q.s2;

endmodule // scl_sync

// ### scl_board.sv
// Board strap resistors and LED loads seen by the strap pins
`timescale 1ns/1ps
module scl_board
   import scl_pkg::*;
(
   input wire scl_pad_s pad,
   input wire logic [15:0] strap_val,
   input wire logic [15:0] strap_en,
   output logic [15:0] pad_lvl
);
   ////////////////////////////////////////////////////////////////////////
   // Driven pin wins, else board strap, else weak internal pull
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (pad.oe[i]) begin
            pad_lvl[i] = pad.out[i];
         end else if (strap_en[i]) begin
            pad_lvl[i] = strap_val[i];
         end else begin
            pad_lvl[i] = pad.pull[i];
         end
      end
   end
endmodule // scl_board

// ### testbench.sv
// Self-checking bench of the strap configuration latch
`timescale 1ns/1ps
module testbench
   import scl_pkg::*;
();
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [6:0] led_on = 7'h00;
   logic [8:0] func_out = 9'h000;
   logic [15:0] strap_val = 16'h0000;
   logic [15:0] strap_en = 16'h0000;
   logic [15:0] pad_i;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, cfg_valid, switch_fwd_en;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   scl_pad_s pad_o;
   scl_dec_s cfg_o;
   int errors = 0;
   int check_count = 0;
   logic [15:0] pats [5] = '{16'h007F, 16'h0000, 16'hFD6B, 16'h309C,
      16'h0073};
   logic [31:0] rd;
   logic [1:0] rsp;

   always #2.5 clk = ~clk;

   scl_strap_latch #(.SOFT_HIZ_CYC(4)) i_dut (.clk(clk), .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .pad_i(pad_i), .pad_o(pad_o),
      .led_on(led_on), .func_out(func_out), .cfg_o(cfg_o),
      .cfg_valid(cfg_valid), .switch_fwd_en(switch_fwd_en));

   scl_board i_board (.pad(pad_o), .strap_val(strap_val),
      .strap_en(strap_en), .pad_lvl(pad_i));

   ////////////////////////////////////////////////////////////////////////
   // Checking and closing
   task automatic chk(input string name, input logic [31:0] e,
         input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask

   task automatic chk_resp(input string name, input logic [1:0] e,
         input logic [1:0] g);
      chk(name, {30'h0, e}, {30'h0, g});
   endtask

   task automatic test_done;
      $display("errors %0d, checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register bus tasks
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
         output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (s_axi_awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
         output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Expected decode of raw strap levels
   function automatic scl_port_s exp_port(input logic [3:0] s);
      scl_port_s o;
      logic [1:0] m;
      m = {s[0], s[1]};
      if (m == 2'h2) m = 2'h0;
      o.mode = scl_pmode_e'(m);
      o.mii_mac_rmii_norm = s[2];
      o.speed_10_100 = s[3];
      o.rmii_ref_out = m == 2'h1 && !s[2];
      o.mii_phy = m == 2'h3 && !s[2];
      return o;
   endfunction

   function automatic scl_dec_s exp_dec(input logic [15:0] p);
      scl_dec_s e;
      logic fast;
      logic [1:0] neg;
      fast = !p[1];
      neg = {p[2], p[3]};
      e.flow_ctrl_en = p[0];
      e.fast_linkup = fast;
      e.autoneg_en = !fast && neg[1] == neg[0];
      e.auto_mdix_en = !fast;
      e.nand_tree = !fast && neg == 2'h2;
      e.full_duplex = fast;
      e.gig_master = fast && p[2];
      e.phy_speed_100 = fast && p[3];
      e.mgmt = p[4] ? SCL_MGMT_SPI : (p[5] ? SCL_MGMT_I2C : SCL_MGMT_MDIO);
      e.switch_start = p[6];
      e.inband_mgmt_en = p[15];
      e.port_a = exp_port(p[10:7]);
      e.port_b = exp_port(p[14:11]);
      return e;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset and configuration checks
   task automatic wait_valid;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cfg_valid !== 1'b1 && n < 50);
      chk("cfg_valid", 32'h1, {31'h0, cfg_valid});
   endtask

   task automatic hw_reset;
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      chk("oe in reset", 32'h0, {16'h0, pad_o.oe});
      rst_b <= 1'b1;
      wait_valid;
   endtask

   task automatic check_cfg(input logic [15:0] p);
      chk("oe", 32'hFFFF, {16'h0, pad_o.oe});
      chk("cfg_o", {8'h0, exp_dec(p)}, {8'h0, cfg_o});
      axi_read(SCL_OFF_CFG, rd, rsp);
      chk("raw straps", {15'h0, 1'b1, p}, rd);
      axi_read(SCL_OFF_DEC, rd, rsp);
      chk("decode", {7'h0, p[6], exp_dec(p)}, rd);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      for (int i = 0; i < 5; i++) begin
         strap_en <= (i == 0) ? 16'h0000 : 16'hFFFF;
         strap_val <= pats[i];
         hw_reset;
         check_cfg(pats[i]);
      end
      strap_val <= 16'h1A77;
      hw_reset;
      chk("nand tree", 32'h1, {31'h0, cfg_o.nand_tree});
      check_cfg(16'h1A77);
      strap_val <= 16'h309C;
      led_on <= 7'h05;
      func_out <= 9'h1A5;
      repeat (2) @(posedge clk);
      chk("pin out", {16'h0, 9'h1A5, 7'h7A}, {16'h0, pad_o.out});
      axi_read(SCL_OFF_CFG, rd, rsp);
      chk("held straps", 32'h11A77, rd);
      axi_write(SCL_OFF_CTRL, 32'h2, rsp);
      chk("oe soft", 32'h0, {16'h0, pad_o.oe});
      wait_valid;
      check_cfg(16'h309C);
      chk("fwd off", 32'h0, {31'h0, switch_fwd_en});
      axi_write(SCL_OFF_CTRL, 32'h1, rsp);
      chk_resp("ctrl wr", SCL_RESP_OKAY, rsp);
      axi_read(SCL_OFF_CTRL, rd, rsp);
      chk("ctrl", 32'h1, rd);
      chk("fwd on", 32'h1, {31'h0, switch_fwd_en});
      axi_read(12'h010, rd, rsp);
      chk_resp("unmapped", SCL_RESP_SLVERR, rsp);
      chk("unmapped data", 32'h0, rd);
      axi_write(SCL_OFF_CFG, 32'h0, rsp);
      chk_resp("ro write", SCL_RESP_OKAY, rsp);
      axi_read(SCL_OFF_CFG, rd, rsp);
      chk("ro kept", {16'h1, 16'h309C}, rd);
      test_done;
   end
endmodule // testbench
